//--- rtl/cpr_cfg.svh
`ifndef CPR_CFG_SVH
`define CPR_CFG_SVH
// Register byte offsets
`define CPR_OFF_PMGT   8'h00
`define CPR_OFF_EXTF   8'h04
`define CPR_OFF_PCTL   8'h08
`define CPR_OFF_STAT   8'h0c
`define CPR_OFF_RSTF   8'h10
`define CPR_OFF_INTC   8'h14
// Field positions
`define CPR_B_DIV_HI   7
`define CPR_B_DIV_LO   6
`define CPR_B_SWB      5
`define CPR_B_CRYSTAL_AMP_OFF    3
`define CPR_B_OSCSEL   3
`define CPR_B_OSCSTS   2
`define CPR_B_RCWAKE   1
`define CPR_B_PDOWN    1
`define CPR_B_XTRDY    4
`define CPR_B_POR      6
`define CPR_B_WDRF     2
`define CPR_B_WDEN     1
`define CPR_B_GIE      7
// Divider codes
`define CPR_DIV_RSVD   2'b00
`define CPR_DIV4       2'b01
`define CPR_DIV64      2'b10
`define CPR_DIV1024    2'b11
// Timing counts in clocks; reset hold in machine cycles
`define CPR_LAST4      10'h003
`define CPR_LAST64     10'h03f
`define CPR_LAST1024   10'h3ff
`define CPR_WDT_LAST   10'h1ff
`define CPR_RST_HOLD   2'h2
// Reset state values
`define CPR_PC_RESET   16'h0000
`define CPR_SP_RESET   8'h07
`define CPR_PORT_RESET 8'hff
`endif

//--- rtl/cpr_pkg.sv
package cpr_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_PDOWN,
    ST_WARM
  } cpr_state_t;

  typedef struct packed {
    logic       gie;
    logic [1:0] level_mode;
    logic [1:0] enable;
  } cpr_intc_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  sp;
    logic [7:0]  port;
  } cpr_rstvec_t;
endpackage

//--- rtl/cpr_top.sv
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "cpr_cfg.svh"
// Function
// R1: Divider code 00 reserved, 01 four, 10 sixty-four, 11 1024 clocks per cycle.
// R2: Peripheral tick runs at the same reduced rate as the core tick.
// R3: New divider setting takes effect one machine cycle later.
// R4: Software goes through divide-by-4 between the two slow rates.
// R5: Source select bit 3 picks crystal or RC; bit 2 reports active source.
// R6: New clock source applies one machine cycle after the write.
// R7: Software clears amplifier off bit before selecting the crystal.
// R8: Crystal ready flag set after warm-up; crystal select refused while clear.
// R9: Switchback enable returns to divide-by-4 on serial or acknowledged interrupt.
// R10: Start bit falling edge with receive enabled, or buffer write, triggers switchback.
// R11: Serial flags ignored; divider writes dropped while serial busy with switchback.
// R12: Every reset source forces divide-by-4.
// R13: Power control bit 1 enters power down after the instruction, stopping clocks.
// R14: Power down drives both strobes low and ports hold their registers.
// R15: Reset pin high ends power down and restarts at zero; watchdog cannot.
// R16: Enabled level interrupt low with global enable wakes and runs its service.
// R17: RC wake select leaves power down on RC, then auto-switches to crystal.
// R18: Reset pin sampled once per machine cycle; pin held two cycles.
// R19: Reset held while pin high plus two machine cycles, then start at zero.
// R20: Power-on flag set after each power-on delay; software clears it.
// R21: Watchdog reset 512 clocks after timeout flag, held two machine cycles.
// R22: Reset state gives program counter zero and stack pointer 07h.
// R23: Ports load FFh, interrupts and timers off; watchdog off only on power-on.
module cpr_top #(
  parameter int XTAL_WARM_CYCLES = 16384
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        rst_pin,
  input  wire logic        power_good_pin,
  input  wire logic        serial_rx_pin,
  input  wire logic [1:0]  ext_int_n_pin,
  input  wire logic        rx_enable,
  input  wire logic        serial_buf_write,
  input  wire logic        serial_busy,
  input  wire logic [1:0]  int_ack,
  input  wire logic        wdt_timeout,
  input  wire logic        wdt_clear,
  output logic             core_tick,
  output logic             periph_tick,
  output logic             osc_crystal_active,
  output logic             crystal_amp_en,
  output logic             osc_run,
  output logic             core_reset,
  output logic             power_down,
  output logic             ale_low,
  output logic             prog_store_strobe_low,
  output logic             port_hold,
  output logic             wake_int,
  output logic [1:0]       wake_int_src,
  output logic             int_timer_off,
  output logic             wdt_disable,
  output cpr_pkg::cpr_rstvec_t reset_vec
);

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int NPIN = 5;
  localparam logic [NPIN-1:0] PIN_IDLE = 5'h1c;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_reg;
  logic [NPIN-1:0] s2_reg;
  logic [NPIN-1:0] s3_reg;
  logic [NPIN-1:0] filt_reg;

  assign pin_raw = {ext_int_n_pin, serial_rx_pin, power_good_pin, rst_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_reg[gi]   <= PIN_IDLE[gi];
          s2_reg[gi]   <= PIN_IDLE[gi];
          s3_reg[gi]   <= PIN_IDLE[gi];
          filt_reg[gi] <= PIN_IDLE[gi];
        end else begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            filt_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  wire       rst_f    = filt_reg[0];
  wire       pgood_f  = filt_reg[1];
  wire       rx_f     = filt_reg[2];
  wire [1:0] int_n_f  = filt_reg[4:3];

  ////////////////////////////////////////////////////////////////
  // State
  cpr_pkg::cpr_state_t state_reg;
  cpr_pkg::cpr_state_t state_next;
  cpr_pkg::cpr_intc_t  intc_reg;
  logic [1:0]  div_req_reg;
  logic [1:0]  div_act_reg;
  logic [9:0]  div_cnt_reg;
  logic        swb_reg;
  logic        crystal_amp_off_reg;
  logic        osc_req_reg;
  logic        osc_act_reg;
  logic        rc_wake_reg;
  logic        auto_sw_reg;
  logic        pd_pend_reg;
  logic [15:0] warm_cnt_reg;
  logic        xt_ready_reg;
  logic [1:0]  hold_reg;
  logic        core_reset_reg;
  logic        por_flag_reg;
  logic        wdrf_reg;
  logic        wden_reg;
  logic        wdt_armed_reg;
  logic        wdt_prev_reg;
  logic [9:0]  wdt_cnt_reg;
  logic        rx_prev_reg;
  logic        pgood_prev_reg;

  ////////////////////////////////////////////////////////////////
  // APB decode
  wire access   = psel && penable;
  wire bus_wr   = access && pwrite && pready;
  wire sel_pmgt = (paddr == `CPR_OFF_PMGT);
  wire sel_extf = (paddr == `CPR_OFF_EXTF);
  wire sel_pctl = (paddr == `CPR_OFF_PCTL);
  wire sel_stat = (paddr == `CPR_OFF_STAT);
  wire sel_rstf = (paddr == `CPR_OFF_RSTF);
  wire sel_intc = (paddr == `CPR_OFF_INTC);
  wire mapped   = sel_pmgt || sel_extf || sel_pctl || sel_stat || sel_rstf || sel_intc;
  wire wr_pmgt  = bus_wr && sel_pmgt;
  wire wr_extf  = bus_wr && sel_extf;
  wire wr_pctl  = bus_wr && sel_pctl;
  wire wr_rstf  = bus_wr && sel_rstf;
  wire wr_intc  = bus_wr && sel_intc;

  wire [1:0] div_wdata = pwdata[`CPR_B_DIV_HI:`CPR_B_DIV_LO];

  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (sel_pmgt) begin
      rdata[`CPR_B_DIV_HI:`CPR_B_DIV_LO] = div_req_reg;
      rdata[`CPR_B_SWB]   = swb_reg;
      rdata[`CPR_B_CRYSTAL_AMP_OFF] = crystal_amp_off_reg;
    end else if (sel_extf) begin
      rdata[`CPR_B_OSCSEL] = osc_req_reg;
      rdata[`CPR_B_OSCSTS] = osc_act_reg;  // R5
      rdata[`CPR_B_RCWAKE] = rc_wake_reg;
    end else if (sel_stat) begin
      rdata[`CPR_B_XTRDY] = xt_ready_reg;
    end else if (sel_rstf) begin
      rdata[`CPR_B_POR]  = por_flag_reg;
      rdata[`CPR_B_WDRF] = wdrf_reg;
      rdata[`CPR_B_WDEN] = wden_reg;
    end else if (sel_intc) begin
      rdata[4:0] = intc_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access && !pready;
      prdata  <= rdata;
      pslverr <= access && !pready && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Machine cycle divider
  wire running = (state_reg == cpr_pkg::ST_RUN);
  wire [9:0] div_last = (div_act_reg == `CPR_DIV1024) ? `CPR_LAST1024 :
                        (div_act_reg == `CPR_DIV64)   ? `CPR_LAST64   : `CPR_LAST4;  // R1
  wire tick = running && (div_cnt_reg == div_last);  // R13

  wire rx_fall  = rx_prev_reg && !rx_f;
  wire int_qual = intc_reg.gie && |(int_ack & intc_reg.enable);
  wire sb_trig  = swb_reg && ((rx_fall && rx_enable) || serial_buf_write || int_qual);  // R9 R10 R11
  wire div_ok   = wr_pmgt && (div_wdata != `CPR_DIV_RSVD) && !(swb_reg && serial_busy);  // R11

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_req_reg <= `CPR_DIV4;
      div_act_reg <= `CPR_DIV4;
      div_cnt_reg <= 10'h000;
    end else if (core_reset_reg) begin
      div_req_reg <= `CPR_DIV4;  // R12
      div_act_reg <= `CPR_DIV4;  // R12
      div_cnt_reg <= (div_cnt_reg >= `CPR_LAST4) ? 10'h000 : div_cnt_reg + 10'h001;  // R21
    end else if (sb_trig) begin
      div_req_reg <= `CPR_DIV4;  // R9
      div_act_reg <= `CPR_DIV4;  // R9
      div_cnt_reg <= 10'h000;
    end else begin
      if (div_ok) begin
        div_req_reg <= div_wdata;  // R4
      end
      if (tick) begin
        div_act_reg <= div_req_reg;  // R3
        div_cnt_reg <= 10'h000;
      end else if (running) begin
        div_cnt_reg <= div_cnt_reg + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Oscillator selection and crystal warm-up
  wire amp_on     = !crystal_amp_off_reg && (state_reg != cpr_pkg::ST_PDOWN);
  wire warm_done  = (warm_cnt_reg == 16'(XTAL_WARM_CYCLES - 1));
  wire wake_lvl   = intc_reg.gie && |(intc_reg.enable & intc_reg.level_mode & ~int_n_f);  // R16
  wire wake_rst   = rst_f;  // R15
  wire pd_exit    = (state_reg == cpr_pkg::ST_PDOWN) && (wake_lvl || wake_rst);
  wire osc_sel_ok = wr_extf && (xt_ready_reg || !pwdata[`CPR_B_OSCSEL]);  // R8 R7

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_cnt_reg <= 16'h0000;
      xt_ready_reg <= 1'b0;
    end else if (!amp_on) begin
      warm_cnt_reg <= 16'h0000;
      xt_ready_reg <= 1'b0;
    end else if (!xt_ready_reg) begin
      warm_cnt_reg <= warm_cnt_reg + 16'h0001;
      xt_ready_reg <= warm_done;  // R8
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_req_reg <= 1'b1;
      osc_act_reg <= 1'b1;
      auto_sw_reg <= 1'b0;
      crystal_amp_off_reg   <= 1'b0;
      rc_wake_reg <= 1'b0;
    end else if (core_reset_reg) begin
      osc_req_reg <= 1'b1;
      osc_act_reg <= osc_act_reg || xt_ready_reg;
      auto_sw_reg <= 1'b0;
      crystal_amp_off_reg   <= 1'b0;
      rc_wake_reg <= 1'b0;
    end else if (pd_exit && rc_wake_reg) begin
      osc_act_reg <= 1'b0;  // R17
      osc_req_reg <= 1'b0;
      auto_sw_reg <= 1'b1;
    end else if (auto_sw_reg && xt_ready_reg) begin
      osc_act_reg <= 1'b1;  // R17
      osc_req_reg <= 1'b1;
      auto_sw_reg <= 1'b0;
    end else begin
      if (osc_sel_ok) begin
        osc_req_reg <= pwdata[`CPR_B_OSCSEL];  // R5
        rc_wake_reg <= pwdata[`CPR_B_RCWAKE];
      end else if (wr_extf) begin
        rc_wake_reg <= pwdata[`CPR_B_RCWAKE];
      end
      if (wr_pmgt && !(osc_act_reg && pwdata[`CPR_B_CRYSTAL_AMP_OFF])) begin
        crystal_amp_off_reg <= pwdata[`CPR_B_CRYSTAL_AMP_OFF];
      end
      if (tick) begin
        osc_act_reg <= osc_req_reg;  // R6
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Power down sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cpr_pkg::ST_RUN: begin
        if (pd_pend_reg && tick) begin
          state_next = cpr_pkg::ST_PDOWN;  // R13
        end
      end
      cpr_pkg::ST_PDOWN: begin
        if (pd_exit) begin
          state_next = (osc_act_reg && !rc_wake_reg) ? cpr_pkg::ST_WARM : cpr_pkg::ST_RUN;
        end
      end
      cpr_pkg::ST_WARM: begin
        if (xt_ready_reg) begin
          state_next = cpr_pkg::ST_RUN;
        end
      end
      default: state_next = cpr_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= cpr_pkg::ST_RUN;
      pd_pend_reg  <= 1'b0;
      wake_int     <= 1'b0;
      wake_int_src <= 2'b00;
    end else begin
      state_reg   <= state_next;
      pd_pend_reg <= !core_reset_reg && (wr_pctl ? pwdata[`CPR_B_PDOWN] : pd_pend_reg && !tick);
      wake_int    <= pd_exit && !wake_rst;  // R16
      if (pd_exit && !wake_rst) begin
        wake_int_src <= intc_reg.enable & intc_reg.level_mode & ~int_n_f;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intc_reg <= '0;
    end else if (core_reset_reg) begin
      intc_reg <= '0;  // R23
    end else if (wr_intc) begin
      intc_reg <= pwdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Reset sources
  wire pf_low   = !pgood_f;
  wire wdt_rise = wdt_timeout && !wdt_prev_reg;
  wire wdt_fire = wdt_armed_reg && running && (wdt_cnt_reg == `CPR_WDT_LAST);  // R21
  wire ext_hit  = tick && rst_f;  // R18
  wire rst_req  = ext_hit || pf_low || wdt_fire;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg       <= `CPR_RST_HOLD;
      core_reset_reg <= 1'b1;
    end else begin
      if (rst_req) begin
        hold_reg <= `CPR_RST_HOLD;  // R19 R21
      end else if (tick && (hold_reg != 2'h0)) begin
        hold_reg <= hold_reg - 2'h1;
      end
      core_reset_reg <= rst_req || (hold_reg != 2'h0) || (core_reset_reg && rst_f);  // R19
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_armed_reg <= 1'b0;
      wdt_cnt_reg   <= 10'h000;
      wdt_prev_reg  <= 1'b0;
    end else begin
      wdt_prev_reg <= wdt_timeout;
      if (wdt_clear || wdt_fire || core_reset_reg) begin
        wdt_armed_reg <= 1'b0;
      end else if (wdt_rise && wden_reg) begin
        wdt_armed_reg <= 1'b1;
        wdt_cnt_reg   <= 10'h000;
      end else if (wdt_armed_reg && running) begin
        wdt_cnt_reg <= wdt_cnt_reg + 10'h001;  // R21
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_flag_reg   <= 1'b1;
      wdrf_reg       <= 1'b0;
      wden_reg       <= 1'b0;
      pgood_prev_reg <= 1'b0;
      rx_prev_reg    <= 1'b1;
    end else begin
      pgood_prev_reg <= pgood_f;
      rx_prev_reg    <= rx_f;
      if (pgood_f && !pgood_prev_reg) begin
        por_flag_reg <= 1'b1;  // R20
      end else if (wr_rstf && !pwdata[`CPR_B_POR]) begin
        por_flag_reg <= 1'b0;  // R20
      end
      if (wdt_fire) begin
        wdrf_reg <= 1'b1;
      end else if (pf_low || (wr_rstf && !pwdata[`CPR_B_WDRF])) begin
        wdrf_reg <= 1'b0;
      end
      if (pf_low) begin
        wden_reg <= 1'b0;  // R23
      end else if (wr_rstf) begin
        wden_reg <= pwdata[`CPR_B_WDEN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_tick             <= 1'b0;
      periph_tick           <= 1'b0;
      power_down            <= 1'b0;
      ale_low               <= 1'b0;
      prog_store_strobe_low <= 1'b0;
      port_hold             <= 1'b0;
      crystal_amp_en        <= 1'b0;
      osc_run               <= 1'b0;
      int_timer_off         <= 1'b1;
      wdt_disable           <= 1'b1;
      reset_vec             <= {`CPR_PC_RESET, `CPR_SP_RESET, `CPR_PORT_RESET};
    end else begin
      core_tick             <= tick;
      periph_tick           <= tick;  // R2
      power_down            <= (state_reg == cpr_pkg::ST_PDOWN);
      ale_low               <= (state_reg == cpr_pkg::ST_PDOWN);  // R14
      prog_store_strobe_low <= (state_reg == cpr_pkg::ST_PDOWN);  // R14
      port_hold             <= (state_reg == cpr_pkg::ST_PDOWN);  // R14
      crystal_amp_en        <= amp_on;
      osc_run               <= (state_reg != cpr_pkg::ST_PDOWN);  // R13
      int_timer_off         <= core_reset_reg;  // R23
      wdt_disable           <= !wden_reg;
      reset_vec             <= {`CPR_PC_RESET, `CPR_SP_RESET, `CPR_PORT_RESET};  // R22 R23
    end
  end

  assign core_reset         = core_reset_reg;  // R22
  assign osc_crystal_active = osc_act_reg;

  ////////////////////////////////////////////////////////////////
  // Assertions
  AST_DIV_FORCED: assert property (@(posedge pclk) disable iff (!presetn)  // R12
    core_reset_reg |=> (div_act_reg == `CPR_DIV4) && (div_req_reg == `CPR_DIV4))
    else $error("divider not forced to four in reset");

  AST_TICK_SPACING: assert property (@(posedge pclk) disable iff (!presetn)  // R1
    tick |-> (div_act_reg == `CPR_DIV4 && div_cnt_reg == 10'h003) ||
             (div_act_reg == `CPR_DIV64 && div_cnt_reg == 10'h03f) ||
             (div_act_reg == `CPR_DIV1024 && div_cnt_reg == 10'h3ff))
    else $error("machine cycle length wrong");

  AST_XTAL_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)  // R8
    wr_extf && pwdata[`CPR_B_OSCSEL] && !xt_ready_reg && !osc_req_reg && !core_reset_reg
      && !auto_sw_reg |=> !osc_req_reg)
    else $error("crystal select accepted before warm-up");

  AST_PD_STROBES: assert property (@(posedge pclk) disable iff (!presetn)  // R14
    (state_reg == cpr_pkg::ST_PDOWN) ##1 (state_reg == cpr_pkg::ST_PDOWN)
      |-> ale_low && prog_store_strobe_low && port_hold && !osc_run)
    else $error("strobes not low in power down");

  AST_PD_NO_TICK: assert property (@(posedge pclk) disable iff (!presetn)  // R13
    (state_reg == cpr_pkg::ST_PDOWN) |-> ##1 !core_tick && !periph_tick)
    else $error("tick during power down");

  AST_SWITCHBACK: assert property (@(posedge pclk) disable iff (!presetn)  // R9
    sb_trig && !core_reset_reg |=> (div_act_reg == `CPR_DIV4) && (div_cnt_reg == 10'h000))
    else $error("switchback did not restore divide by four");

  AST_DIV_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)  // R11
    wr_pmgt && swb_reg && serial_busy && !core_reset_reg |=> $stable(div_req_reg))
    else $error("divider write taken while serial busy");

  AST_RST_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn)  // R18
    ext_hit |=> core_reset_reg [*4])
    else $error("external reset not held");

  AST_WDT_FIRE: assert property (@(posedge pclk) disable iff (!presetn)  // R21
    wdt_fire |=> core_reset_reg && wdrf_reg && (hold_reg == 2'h2))
    else $error("watchdog expiry gave no reset");

  AST_DIV_DELAY: assert property (@(posedge pclk) disable iff (!presetn)  // R3
    div_ok && !tick && !sb_trig && !core_reset_reg |=> $stable(div_act_reg))
    else $error("divider applied without delay");

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swb_reg <= 1'b0;
    end else if (core_reset_reg) begin
      swb_reg <= 1'b0;
    end else if (wr_pmgt) begin
      swb_reg <= pwdata[`CPR_B_SWB];
    end
  end

endmodule

//--- dv/cpr_top_bench.sv
`timescale 1ns/1ps
`include "cpr_cfg.svh"
module cpr_top_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat, per;
  logic        rerr, rst_pin, power_good_pin, serial_rx_pin, rx_enable;
  logic        serial_buf_write, serial_busy, wdt_timeout, core_tick, periph_tick;
  logic        osc_crystal_active, core_reset, power_down, ale_low, psl, port_hold;
  logic        osc_run, wake_int, wdt_disable, wdt_clear, amp, ito;
  logic [1:0]  ext_int_n_pin, wake_int_src, int_ack;
  cpr_pkg::cpr_rstvec_t reset_vec;
  int          mismatches, n_compared, n, i;
  localparam logic [7:0]  RA [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18};
  localparam logic [31:0] RM [6] = '{32'hc0, 32'h08, 32'hff, 32'h46, 32'h1f, 32'hffffffff};
  localparam logic [31:0] RX [6] = '{32'h40, 32'h08, 32'h00, 32'h40, 32'h00, 32'h00};
  localparam logic [1:0]  DW [5] = '{2'b10, 2'b01, 2'b11, 2'b00, 2'b01};
  localparam logic [31:0] DP [5] = '{32'd64, 32'd4, 32'd1024, 32'd1024, 32'd4};

  cpr_top #(.XTAL_WARM_CYCLES(16)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rst_pin(rst_pin), .power_good_pin(power_good_pin), .serial_rx_pin(serial_rx_pin),
    .ext_int_n_pin(ext_int_n_pin), .rx_enable(rx_enable), .serial_buf_write(serial_buf_write),
    .serial_busy(serial_busy), .int_ack(int_ack), .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear),
    .core_tick(core_tick), .periph_tick(periph_tick), .osc_crystal_active(osc_crystal_active),
    .crystal_amp_en(amp), .osc_run(osc_run), .core_reset(core_reset), .power_down(power_down),
    .ale_low(ale_low), .prog_store_strobe_low(psl), .port_hold(port_hold), .wake_int(wake_int),
    .wake_int_src(wake_int_src), .int_timer_off(ito), .wdt_disable(wdt_disable), .reset_vec(reset_vec));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) mismatches++;
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task period;
    int k;
    k = 0;
    @(posedge pclk);
    while (core_tick !== 1'b1 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    chk("periph_tick", core_tick, periph_tick);
    per = 0;
    do begin
      @(posedge pclk);
      per++;
    end while (core_tick !== 1'b1 && per < 3000);
  endtask

  task div_chk(input logic [31:0] d, input logic [31:0] p);
    apb(1'b1, `CPR_OFF_PMGT, d);
    period;
    period;
    chk("tick period", p, per);
  endtask

  task wait_run;
    n = 0;
    while (core_reset !== 1'b0 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) mismatches++;
  endtask

  task wait_rst(input int lim);
    n = 0;
    while (core_reset !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task pdown;
    apb(1'b1, `CPR_OFF_PCTL, 32'h2);
    n = 0;
    while (power_down !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task sb_pulse(input logic tx, input logic [1:0] ack);
    div_chk(32'ha0, 32'd64);
    serial_buf_write <= tx;
    int_ack          <= ack;
    @(posedge pclk);
    serial_buf_write <= 1'b0;
    int_ack          <= 2'b00;
    period;
  endtask

  task int_wake;
    pdown;
    ext_int_n_pin <= 2'b10;
    n = 0;
    while (wake_int !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk("wake src", 2'b01, wake_int_src);
    ext_int_n_pin <= 2'b11;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    mismatches++;
    close_out;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, rst_pin, rx_enable} = '0;
    {serial_buf_write, serial_busy, wdt_timeout, int_ack, wdt_clear, mismatches, n_compared} = '0;
    power_good_pin = 1'b1;
    serial_rx_pin  = 1'b1;
    ext_int_n_pin  = 2'b11;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("core_reset", 1'b1, core_reset);
    chk("reset_vec", {16'h0000, 8'h07, 8'hff}, reset_vec);
    chk("wdt_disable", 1'b1, wdt_disable);
    chk("int_timer_off", 1'b1, ito);
    wait_run;
    for (i = 0; i < 6; i++) begin
      apb(1'b0, RA[i], 32'h0);
      chk("reset read", RX[i], rdat & RM[i]);
      chk("slverr", RA[i] == 8'h18, rerr);
    end
    for (i = 0; i < 5; i++)
      div_chk({24'h0, DW[i], 6'h0}, DP[i]);
    sb_pulse(1'b1, 2'b00);
    chk("tx switchback", 32'd4, per);
    serial_busy <= 1'b1;
    div_chk(32'ha0, 32'd4);
    serial_busy <= 1'b0;
    div_chk(32'ha0, 32'd64);
    rx_enable     <= 1'b1;
    serial_rx_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    period;
    chk("rx switchback", 32'd4, per);
    serial_rx_pin <= 1'b1;
    rx_enable     <= 1'b0;
    apb(1'b1, `CPR_OFF_EXTF, 32'h0);
    period;
    div_chk(32'h48, 32'd4);
    apb(1'b0, `CPR_OFF_EXTF, 32'h0);
    chk("rc active", 32'h0, rdat & 32'hc);
    apb(1'b0, `CPR_OFF_STAT, 32'h0);
    chk("xtal not ready", 32'h0, rdat & 32'h10);
    apb(1'b1, `CPR_OFF_EXTF, 32'h8);
    apb(1'b0, `CPR_OFF_EXTF, 32'h0);
    chk("xtal refused", 32'h0, rdat & 32'h8);
    apb(1'b1, `CPR_OFF_PMGT, 32'h40);
    repeat (60) @(posedge pclk);
    apb(1'b0, `CPR_OFF_STAT, 32'h0);
    chk("xtal ready", 32'h10, rdat & 32'h10);
    apb(1'b1, `CPR_OFF_EXTF, 32'h8);
    period;
    period;
    apb(1'b0, `CPR_OFF_EXTF, 32'h0);
    chk("xtal active", 32'hc, rdat & 32'hc);
    apb(1'b1, `CPR_OFF_RSTF, 32'h0);
    apb(1'b0, `CPR_OFF_RSTF, 32'h0);
    chk("por cleared", 32'h0, rdat & 32'h40);
    apb(1'b1, `CPR_OFF_PMGT, 32'h80);
    pdown;
    chk("pdown pins", 5'b11100, {ale_low, psl, port_hold, osc_run, amp});
    rst_pin <= 1'b1;
    wait_rst(300);
    chk("rst wake", 2'b01, {power_down, core_reset});
    rst_pin <= 1'b0;
    wait_run;
    apb(1'b0, `CPR_OFF_PMGT, 32'h0);
    chk("div after reset", 32'h40, rdat & 32'hc0);
    apb(1'b0, `CPR_OFF_RSTF, 32'h0);
    chk("no ext flag", 32'h0, rdat & 32'h44);
    apb(1'b1, `CPR_OFF_INTC, 32'h15);
    int_wake;
    repeat (4) @(posedge pclk);
    chk("awake", 1'b0, power_down);
    sb_pulse(1'b0, 2'b01);
    chk("int switchback", 32'd4, per);
    apb(1'b1, `CPR_OFF_EXTF, 32'ha);
    int_wake;
    chk("rc wake", 1'b0, osc_crystal_active);
    repeat (40) @(posedge pclk);
    chk("auto crystal", 1'b1, osc_crystal_active);
    apb(1'b1, `CPR_OFF_RSTF, 32'h2);
    wdt_timeout <= 1'b1;
    repeat (10) @(posedge pclk);
    wdt_clear <= 1'b1;
    @(posedge pclk);
    wdt_clear <= 1'b0;
    wait_rst(600);
    chk("wdt cleared", 1'b0, core_reset);
    wdt_timeout <= 1'b0;
    @(posedge pclk);
    wdt_timeout <= 1'b1;
    wait_rst(700);
    chk("wdt delay", 1'b1, n >= 510 && n <= 530);
    wdt_timeout <= 1'b0;
    wait_run;
    apb(1'b0, `CPR_OFF_RSTF, 32'h0);
    chk("wdt flags", 32'h6, rdat & 32'h46);
    chk("wdt kept", 1'b0, wdt_disable);
    close_out;
  end
endmodule
